// file: hw/pls_cfg_defs.svh
/*
 register offsets, field positions, reset values for the port config bank.
 assumes: included by pls_cfg_regs only, not by the package, no processes here.
*/
`ifndef PLS_CFG_DEFS_SVH
`define PLS_CFG_DEFS_SVH
`define PLS_OFF_SLOT_CTRL_STAT 8'hd8
`define PLS_OFF_DEV_CAP2 8'he4
`define PLS_OFF_DEV_CTRL2 8'he8
`define PLS_OFF_LINK_CAP2 8'hec
`define PLS_OFF_LINK_CTRL2 8'hf0
`define PLS_OFF_SLOT_CAP2 8'hf4
`define PLS_OFF_SLOT_CTRL2 8'hf8
`define PLS_OFF_STRAP 8'hfc
`define PLS_BIT_ATTN 16
`define PLS_BIT_PFAULT 17
`define PLS_BIT_LATCH_CHG 18
`define PLS_BIT_PRES_CHG 19
`define PLS_BIT_CMD_DONE 20
`define PLS_BIT_LATCH_STATE 21
`define PLS_BIT_PRES_STATE 22
`define PLS_BIT_DLL_CHG 24
`define PLS_BIT_HP_INT_EN 5
`define PLS_BIT_DLL_EN 12
`define PLS_BIT_LTR_SUP 11
`define PLS_BIT_FC_LTR 12
`define PLS_BIT_OBFF_LO 18
`define PLS_BIT_LTR_EN 10
`define PLS_BIT_OBFF_EN_LO 13
`define PLS_BIT_DEEMP_SEL 6
`define PLS_BIT_DEEMP_CUR 16
`define PLS_RST_SLOT_CTRL 16'h01c0
`define PLS_RST_TARGET_SPEED 4'h2
`endif

// file: hw/pls_cfg_pkg.sv
/*
 types for the port config bank.
 assumes: the defs header carries all numbers.
*/
package pls_cfg_pkg;
   typedef enum logic [2:0] {
      pls_idle_type_st = 3'b001,
      pls_access_type_st = 3'b010,
      pls_done_type_st = 3'b100
   } pls_apb_state_type;
endpackage

// file: hw/pls_cfg_regs.sv
/*
 config-space register bank for one switch port: slot event status,
 device/link capability-2 group, de-emphasis reset straps.
 assumes: apb master on pclk; hot-plug pins asynchronous; preload strap
 inputs stable before and after reset release.
*/
`timescale 1ns/1ps
`include "pls_cfg_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] attention button press sets bit 16; write one clears; resets zero
// [R2] power fault sets bit 17; write one clears; resets zero
// [R3] bit 18 latch sensor change flag, read-only, resets zero, writes ignored
// [R4] presence change sets bit 19; write one clears; resets zero
// [R5] hot-plug command completion sets bit 20; write one clears; resets zero
// [R6] bit 21 mirrors retention latch: zero closed, one open; resets zero
// [R7] bit 22 shows card presence: zero empty, one present; resets zero
// [R8] downstream port without slot reads presence state as one
// [R9] link-active change sets bit 24; write one clears
// [R10] device capabilities 2 bit 11 reads one (latency reporting)
// [R11] flush/fill support field bits 19:18 resets to zero
// [R12] bit 12, flush/fill support and de-emphasis select preloaded from straps
// [R13] device control 2 bits 14:13 read-write flush/fill enable, reset zero
// [R14] de-emphasis select bit 6 takes effect only on downstream ports
// [R15] upstream port resets de-emphasis select and current level to zero
// [R16] downstream port resets de-emphasis select and current level to one
// [R17] hot-plug interrupt needs master enable and the event's own enable
// [R18] capability-2 link/slot words and reserved bits read zero
// [R19] writing zero keeps flags; event in clearing cycle keeps flag set
module pls_cfg_regs
   import pls_cfg_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // port straps (static)
   input wire logic is_downstream,
   input wire logic slot_implemented,
   input wire logic preload_valid,
   input wire logic preload_fc_ltr,
   input wire logic [1:0] preload_obff_sup,
   input wire logic preload_deemp_sel,
   // hot-plug pins
   input wire logic attn_button,
   input wire logic power_fault,
   input wire logic retention_latch,
   input wire logic card_present,
   input wire logic link_active,
   // hot-plug controller
   input wire logic cmd_done,
   // outputs to core
   output logic hot_plug_irq,
   output logic ltr_enable,
   output logic [1:0] obff_enable,
   output logic [3:0] target_speed,
   output logic deemp_sel_eff,
   output logic deemp_current
);
////////////////////////////////////////////////////////////////////////////////
   logic [4:0] pin_sync;
   logic [4:0] pin_rise;
   logic [4:0] pin_change;
   logic rst_done;
   logic strap_ds;
   logic deemp_sel;
   logic fc_ltr;
   logic [1:0] obff_sup;
   logic [12:0] slot_ctrl;
   logic [4:0] flags;
   logic dll_chg;
   logic [12:0] link_ctrl;
   pls_apb_state_type state;
   pls_apb_state_type next_state;
   // pins have no relation to pclk; two flops before any logic reads them
   pls_sync #(.WIDTH(5)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({link_active, card_present, retention_latch, power_fault, attn_button}),
      .sync_out(pin_sync)
   );
   pls_edge #(.WIDTH(5)) u_edge
   (
      .pclk(pclk),
      .presetn(presetn),
      .level(pin_sync),
      .rise(pin_rise),
      .change(pin_change)
   );
////////////////////////////////////////////////////////////////////////////////
   // apb: one wait state; access phase answers in its second cycle
   wire setup_ok = psel & ~penable;
   always_comb
   begin
      case (state)
         pls_idle_type_st: next_state = setup_ok ? pls_access_type_st : pls_idle_type_st;
         pls_access_type_st: next_state = (psel & penable) ? pls_done_type_st : pls_access_type_st;
         pls_done_type_st: next_state = pls_idle_type_st;
         default: next_state = pls_idle_type_st;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= pls_idle_type_st;
      else
         state <= next_state;
   end
   assign pready = (state == pls_done_type_st);
   wire wr_fire = pready & psel & penable & pwrite;
   wire hit_slot = (paddr == `PLS_OFF_SLOT_CTRL_STAT);
   wire hit_dctl = (paddr == `PLS_OFF_DEV_CTRL2);
   wire hit_lctl = (paddr == `PLS_OFF_LINK_CTRL2);
   wire mapped = hit_slot | hit_dctl | hit_lctl | (paddr == `PLS_OFF_DEV_CAP2)
      | (paddr == `PLS_OFF_LINK_CAP2) | (paddr == `PLS_OFF_SLOT_CAP2)
      | (paddr == `PLS_OFF_SLOT_CTRL2) | (paddr == `PLS_OFF_STRAP);
   // unmapped or misaligned: error, reads zero, writes dropped
   assign pslverr = pready & ~mapped;
////////////////////////////////////////////////////////////////////////////////
   // strap capture one edge after reset release; straps are static, so one
   // capture replaces a synchroniser
   // upstream zero, downstream one unless preloaded
   wire deemp_default = preload_valid ? preload_deemp_sel : 1'b1;
   wire fc_ltr_default = preload_valid & preload_fc_ltr;
   wire [1:0] obff_default = preload_valid ? preload_obff_sup : 2'h0;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_done <= 1'b0;
         strap_ds <= 1'b0;
         deemp_sel <= 1'b0;
         fc_ltr <= 1'b0;
         obff_sup <= 2'h0;                                     // [R11]
      end
      else if (!rst_done)
      begin
         rst_done <= 1'b1;
         strap_ds <= is_downstream;
         fc_ltr <= fc_ltr_default;                             // [R12]
         obff_sup <= obff_default;                             // [R12]
         deemp_sel <= is_downstream & deemp_default;           // [R15] [R16] [R12]
      end
   end
   assign deemp_sel_eff = strap_ds & deemp_sel;                // [R14]
   assign deemp_current = deemp_sel_eff;                       // [R15] [R16]
////////////////////////////////////////////////////////////////////////////////
   // slot control and link/device control 2
   wire [15:0] wr_lo = pwdata[15:0];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_ctrl <= 13'(`PLS_RST_SLOT_CTRL);
         link_ctrl <= {8'h00, 1'b0, `PLS_RST_TARGET_SPEED};
         ltr_enable <= 1'b0;
         obff_enable <= 2'h0;                                  // [R13]
      end
      else if (wr_fire)
      begin
         if (hit_slot)
            slot_ctrl <= wr_lo[12:0];
         if (hit_lctl)
            link_ctrl <= {wr_lo[12:7], 1'b0, wr_lo[5:0]};
         if (hit_dctl)
         begin
            ltr_enable <= wr_lo[`PLS_BIT_LTR_EN];
            obff_enable <= wr_lo[14:13];                      // [R13]
         end
      end
   end
   assign target_speed = link_ctrl[3:0];
////////////////////////////////////////////////////////////////////////////////
   // event flags: set beats clear, zero writes ignored
   wire [4:0] clr_req = {5{wr_fire & hit_slot}} & {pwdata[24], pwdata[20:19], pwdata[17:16]};
   wire [4:0] set_ev = {pin_change[4], cmd_done, pin_change[3], pin_rise[1], pin_rise[0]};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags <= 5'h00;
      else
         flags <= set_ev | (flags & ~clr_req);                // [R1] [R2] [R4] [R5] [R9] [R19]
   end
   // latch change bit is read-only; held set from the first latch change until reset, never cleared by software
   logic latch_chg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         latch_chg <= 1'b0;
      else if (pin_change[2])
         latch_chg <= 1'b1;                                    // [R3]
   end
   assign dll_chg = flags[4];
   wire pres_state = (strap_ds & ~slot_implemented) ? 1'b1 : pin_sync[3]; // [R7] [R8]
   // enable order: attn, pfault, latch, presence, cmd; plus dll
   wire [5:0] ev_hit = {dll_chg & slot_ctrl[`PLS_BIT_DLL_EN], flags[3] & slot_ctrl[4],
      flags[2] & slot_ctrl[3], latch_chg & slot_ctrl[2], flags[1] & slot_ctrl[1],
      flags[0] & slot_ctrl[0]};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hot_plug_irq <= 1'b0;
      else
         hot_plug_irq <= slot_ctrl[`PLS_BIT_HP_INT_EN] & (|ev_hit); // [R17]
   end
////////////////////////////////////////////////////////////////////////////////
   // read mux; data captured in the access cycle so it is settled while pready stands
   wire [31:0] rd_slot = {7'h00, dll_chg, 1'b0, pres_state, pin_sync[2], flags[3],
      flags[2], latch_chg, flags[1], flags[0], 3'h0, slot_ctrl};      // [R6] [R3]
   wire [31:0] rd_dcap = {12'h000, obff_sup, 5'h00, fc_ltr, 1'b1, 11'h000}; // [R10] [R11]
   wire [31:0] rd_dctl = {16'h0000, 1'b0, obff_enable, 2'h0, ltr_enable, 10'h000};
   wire [31:0] rd_lctl = {15'h0000, deemp_current, 3'h0, link_ctrl[12:7], deemp_sel_eff,
      link_ctrl[5:0]};
   wire [31:0] rd_strap = {29'h0, slot_implemented, strap_ds, rst_done};
   logic [31:0] rd_mux;
   always_comb
   begin
      case (paddr)
         `PLS_OFF_SLOT_CTRL_STAT: rd_mux = rd_slot;
         `PLS_OFF_DEV_CAP2: rd_mux = rd_dcap;
         `PLS_OFF_DEV_CTRL2: rd_mux = rd_dctl;
         `PLS_OFF_LINK_CTRL2: rd_mux = rd_lctl;
         `PLS_OFF_STRAP: rd_mux = rd_strap;
         default: rd_mux = 32'h0000_0000;                      // [R18]
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (state == pls_access_type_st && !pwrite)
         prdata <= rd_mux;
   end
////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // event flags: sets
   chk_attn_sets: assert property (pin_rise[0] |=> flags[0]) // [R1]
      else $error("attention flag not set");
   chk_pfault_sets: assert property (pin_rise[1] |=> flags[1]) // [R2]
      else $error("power fault flag not set");
   chk_latch_ro: assert property (latch_chg |=> latch_chg) // [R3]
      else $error("latch change flag cleared");
   chk_pres_sets: assert property (pin_change[3] |=> flags[2]) // [R4]
      else $error("presence flag not set");
   chk_cmd_sets: assert property (cmd_done |=> flags[3]) // [R5]
      else $error("command flag not set");
   chk_latch_mirror: assert property (rd_slot[21] == pin_sync[2]) // [R6]
      else $error("latch state mismatch");
   chk_noslot_pres: assert property (strap_ds && !slot_implemented |-> rd_slot[22]) // [R8]
      else $error("presence not forced");
   chk_dll_sets: assert property (pin_change[4] |=> dll_chg) // [R9]
      else $error("link change flag not set");
   chk_ltr_sup: assert property (rd_dcap[11]) // [R10]
      else $error("ltr support not one");
   chk_deemp_up: assert property (rst_done && !strap_ds |-> !deemp_sel && !deemp_current) // [R15]
      else $error("upstream de-emphasis not zero");
   chk_irq_gate: assert property (hot_plug_irq |-> $past(slot_ctrl[5])) // [R17]
      else $error("interrupt without master enable");
   chk_zero_keep: assert property (wr_fire && hit_slot && !pwdata[16] && flags[0] // [R19]
      |=> flags[0])
      else $error("zero write cleared flag");
   chk_ready_gap: assert property (pready |=> !pready) // [R18]
      else $error("ready held two cycles");
   chk_err_gate: assert property (pslverr |-> pready) // [R18]
      else $error("error without ready");
   // clears: a one clears a flag only when no new event arrives with it
   chk_attn_clear: assert property (clr_req[0] && !set_ev[0] |=> !flags[0]) // [R1]
      else $error("attention flag not cleared");
   chk_pfault_clear: assert property (clr_req[1] && !set_ev[1] |=> !flags[1]) // [R2]
      else $error("power fault flag not cleared");
   chk_latch_sets: assert property (pin_change[2] |=> latch_chg) // [R3]
      else $error("latch change flag not set");
   chk_pres_clear: assert property (clr_req[2] && !set_ev[2] |=> !flags[2]) // [R4]
      else $error("presence flag not cleared");
   chk_cmd_clear: assert property (clr_req[3] && !set_ev[3] |=> !flags[3]) // [R5]
      else $error("command flag not cleared");
   chk_pres_mirror: assert property (!(strap_ds && !slot_implemented) // [R7]
      |-> rd_slot[22] == pin_sync[3])
      else $error("presence state mismatch");
   chk_dll_clear: assert property (clr_req[4] && !set_ev[4] |=> !dll_chg) // [R9]
      else $error("link change flag not cleared");
   chk_rsvd_slot: assert property (rd_slot[31:25] == 7'h00 && !rd_slot[23]) // [R18]
      else $error("reserved slot bits not zero");
   chk_flag_hold: assert property (clr_req == 5'h00 && set_ev == 5'h00 // [R19]
      |=> flags == $past(flags))
      else $error("flags moved without event or clear");
   chk_set_wins: assert property (clr_req[2] && set_ev[2] |=> flags[2]) // [R19]
      else $error("clear beat a new presence event");
   // straps and de-emphasis
   chk_sup_rst: assert property ($rose(rst_done) && !preload_valid // [R11]
      |-> obff_sup == 2'h0 && !fc_ltr)
      else $error("flush/fill support not zero");
   chk_cap_stable: assert property (rst_done |=> $stable(obff_sup) && $stable(fc_ltr)) // [R12]
      else $error("preloaded capability moved");
   chk_deemp_stable: assert property (rst_done |=> $stable(deemp_sel)) // [R12]
      else $error("preloaded de-emphasis moved");
   chk_dctl_write: assert property (wr_fire && hit_dctl // [R13]
      |=> obff_enable == $past(pwdata[14:13]) && ltr_enable == $past(pwdata[10]))
      else $error("device control 2 write lost");
   chk_dctl_hold: assert property (!(wr_fire && hit_dctl) // [R13]
      |=> $stable(obff_enable) && $stable(ltr_enable))
      else $error("device control 2 moved without write");
   chk_deemp_ro: assert property (wr_fire && hit_lctl // [R14]
      |=> $stable(deemp_sel_eff) && $stable(deemp_current))
      else $error("de-emphasis select written");
   chk_deemp_down: assert property ($rose(rst_done) && strap_ds && !preload_valid // [R16]
      |-> deemp_sel_eff && deemp_current)
      else $error("downstream de-emphasis not one");
   // interrupt and refusals
   chk_irq_event: assert property (ev_hit == 6'h00 |=> !hot_plug_irq) // [R17]
      else $error("interrupt without enabled event");
   chk_irq_raise: assert property (slot_ctrl[5] && ev_hit != 6'h00 |=> hot_plug_irq) // [R17]
      else $error("enabled event raised no interrupt");
   chk_cap2_zero: assert property (paddr == `PLS_OFF_LINK_CAP2 // [R18]
      || paddr == `PLS_OFF_SLOT_CAP2 || paddr == `PLS_OFF_SLOT_CTRL2 |-> rd_mux == 32'h0)
      else $error("capability 2 word not zero");
   chk_unmapped_zero: assert property (!mapped |-> rd_mux == 32'h0) // [R18]
      else $error("unmapped read not zero");
   chk_err_nowrite: assert property (wr_fire && !mapped // [R18]
      |=> $stable(slot_ctrl) && $stable(link_ctrl))
      else $error("refused write changed a register");
   cov_w1c: cover property (wr_fire && hit_slot && |clr_req);
   cov_irq: cover property ($rose(hot_plug_irq));
   cov_dctl_wr: cover property (wr_fire && hit_dctl);
   cov_err: cover property (pslverr);
   cov_dll: cover property (pin_change[4]);
endmodule

// file: hw/pls_edge.sv
/*
 rising/any-change detector on synchronised levels, one per bit.
 assumes: input already synchronised to pclk.
*/
`timescale 1ns/1ps
module pls_edge
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // levels and events
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] change
);
   logic [WIDTH-1:0] prev;
   logic [2:0] fill;
   logic armed;
   // silent until prev holds a synchronised pin value: a pin already high
   // at reset release must not look like an edge against the reset zeros
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev <= '0;
         fill <= 3'h0;
      end
      else
      begin
         prev <= level;
         fill <= {fill[1:0], 1'b1};
      end
   end
   assign armed = fill[2];
   genvar i;
   for (i = 0; i < WIDTH; i++)
   begin : g_bit
      assign rise[i] = armed & level[i] & ~prev[i];
      assign change[i] = armed & (level[i] ^ prev[i]);
   end
endmodule

// file: hw/pls_sync.sv
/*
 two flip-flop synchroniser, one per bit.
 assumes: inputs are asynchronous pins.
*/
`timescale 1ns/1ps
module pls_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// file: tb/pls_cfg_regs_tb.sv
/*
 self-checking bench for the port config bank, apb master tasks.
 assumes: one wait state slaves are fine, waits are bounded anyway.
*/
`timescale 1ns/1ps
module pls_cfg_regs_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat, st, f;
   logic is_downstream, slot_implemented, preload_valid, preload_fc_ltr, preload_deemp_sel;
   logic [1:0] preload_obff_sup, obff_enable;
   logic attn_button, power_fault, retention_latch, card_present, link_active, cmd_done;
   logic hot_plug_irq, ltr_enable, deemp_sel_eff, deemp_current;
   logic [3:0] target_speed;
   int num_errors = 0;
   int n_tests = 0;
   int fb[6] = '{16, 17, 18, 19, 20, 24};
   logic [7:0] ra[7] = '{8'hd8, 8'he4, 8'he8, 8'hec, 8'hf0, 8'hf4, 8'hf8};
   logic [31:0] re[7] = '{32'h000001c0, 32'h00000800, 0, 0, 32'h00010042, 0, 0};
   pls_cfg_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .is_downstream(is_downstream), .slot_implemented(slot_implemented),
      .preload_valid(preload_valid), .preload_fc_ltr(preload_fc_ltr),
      .preload_obff_sup(preload_obff_sup), .preload_deemp_sel(preload_deemp_sel),
      .attn_button(attn_button), .power_fault(power_fault),
      .retention_latch(retention_latch), .card_present(card_present),
      .link_active(link_active), .cmd_done(cmd_done), .hot_plug_irq(hot_plug_irq),
      .ltr_enable(ltr_enable), .obff_enable(obff_enable), .target_speed(target_speed),
      .deemp_sel_eff(deemp_sel_eff), .deemp_current(deemp_current));
   pls_slot_model m_u (.pclk(pclk), .attn_button(attn_button), .power_fault(power_fault),
      .retention_latch(retention_latch), .card_present(card_present),
      .link_active(link_active), .cmd_done(cmd_done));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // whole request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      chk(32'(k < 20), 32'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   // straps change only inside reset, the bank samples them once after release
   task automatic do_reset(input logic [6:0] s);
      presetn <= 1'b0;
      m_u.clear();
      {is_downstream, slot_implemented, preload_valid, preload_fc_ltr} <= s[6:3];
      {preload_obff_sup, preload_deemp_sel} <= s[2:0];
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      do_reset(7'b1100000);
      for (int i = 0; i < 7; i++)
         rd(ra[i], re[i]);
      chk(32'({deemp_sel_eff, deemp_current, target_speed}), 32'h32);
      rd(8'hfc, 32'h00000007);
      $display("test reset values done");
      st = 32'h0;
      for (int i = 0; i < 6; i++)
      begin
         m_u.hit(i);
         repeat (6) @(posedge pclk);
         if (i == 2) st = st | 32'h00240000;
         if (i == 3) st = st | 32'h00400000;
         f = 32'h1 << fb[i];
         rd(8'hd8, 32'h1c0 | st | f);
         if (i == 0)
         begin
            wr(8'hd8, 32'h000001e1);
            repeat (3) @(posedge pclk);
            chk(32'(hot_plug_irq), 32'h1);
            wr(8'hd8, 32'h000001e0);
            repeat (3) @(posedge pclk);
            chk(32'(hot_plug_irq), 32'h0);
            wr(8'hd8, 32'h000001c1);
            repeat (3) @(posedge pclk);
            chk(32'(hot_plug_irq), 32'h0);
         end
         wr(8'hd8, 32'h000001c0);
         rd(8'hd8, 32'h1c0 | st | f);
         wr(8'hd8, 32'h1c0 | f);
         rd(8'hd8, 32'h1c0 | st);
      end
      $display("test slot events done");
      wr(8'he8, 32'hffffffff);
      rd(8'he8, 32'h00006400);
      chk(32'({ltr_enable, obff_enable}), 32'h7);
      for (int i = 1; i < 7; i++)
      begin
         wr(ra[i], (i == 4) ? 32'h0 : 32'hffffffff);
         if (i != 2)
            rd(ra[i], (i == 4) ? 32'h00010040 : re[i]);
      end
      chk(32'({deemp_sel_eff, target_speed}), 32'h10);
      wr(8'h40, 32'hffffffff);
      rd(8'h40, 32'h0);
      chk(32'(rerr), 32'h1);
      $display("test control and refusals done");
      do_reset(7'b1011100);
      rd(8'he4, 32'h00081800);
      rd(8'hd8, 32'h004001c0);
      rd(8'hfc, 32'h00000003);
      rd(8'hf0, 32'h00000002);
      chk(32'({rdat[6], deemp_sel_eff}), 32'h0);
      do_reset(7'b0000000);
      rd(8'hf0, 32'h00000002);
      rd(8'hfc, 32'h00000001);
      chk(32'(deemp_current), 32'h0);
      $display("test strap variants done");
      end_sim();
   end
   initial
   begin
      repeat (6000) @(posedge pclk);
      num_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_sim();
   end
endmodule

// file: tb/pls_slot_model.sv
/*
 slot side model: hot-plug pins and the controller's completion strobe.
 assumes: bench calls hit and clear right after a pclk edge.
*/
`timescale 1ns/1ps
module pls_slot_model
(
   // clock
   input wire logic pclk,
   // slot pins
   output logic attn_button,
   output logic power_fault,
   output logic retention_latch,
   output logic card_present,
   output logic link_active,
   output logic cmd_done
);
   initial
   begin
      {attn_button, power_fault, retention_latch} = 3'h0;
      {card_present, link_active, cmd_done} = 3'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // pins toggle as levels; the strobe is one cycle, like the real controller
   task automatic hit(input int i);
      case (i)
         0: attn_button <= ~attn_button;
         1: power_fault <= ~power_fault;
         2: retention_latch <= ~retention_latch;
         3: card_present <= ~card_present;
         4: cmd_done <= 1'b1;
         default: link_active <= ~link_active;
      endcase
      @(posedge pclk);
      cmd_done <= 1'b0;
   endtask
   task automatic clear();
      {attn_button, power_fault, retention_latch} <= 3'h0;
      {card_present, link_active, cmd_done} <= 3'h0;
   endtask
endmodule
